/* hdl/irq_wake_core.sv */
// Core end: Avalon-MM registers driving the interrupt/wake device
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"
module irq_wake_core (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic [`AVS_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  irq_link_if.core link // Device side
);
  import irq_pkg::*;

  host_state_t st_ff;
  host_state_t nxt_st;
  logic req;
  logic [31:0] rd;

  assign req = avs_read | avs_write;

  // Read mux, unmapped reads as zero
  always_comb begin
    rd = '0;
    unique case (avs_address)
      `REG_MASK: rd[`MASK_W-1:0] = link.mask_rdata;
      `REG_CTRL: rd[`CTRL_LVL_LSB +: 2] = st_ff.lvl;
      `REG_STATUS: begin
        rd[`SRC_N-1:0] = link.pending;
        rd[`STAT_IRQ_BIT] = link.irq_req;
        rd[`STAT_MODE_LSB +: 3] = link.lp_mode;
        rd[`STAT_RUN_BIT] = link.cpu_run;
      end
      default: rd = '0;
    endcase
  end

  // One wait cycle, writes act at the answer edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mask_wr = 1'b0;
    nxt_st.idle_req = 1'b0;
    nxt_st.pd_req = 1'b0;
    nxt_st.clr = '0;
    nxt_st.waitreq = ~(req & st_ff.waitreq);
    if (req && st_ff.waitreq) begin
      nxt_st.readdata = avs_read ? rd : '0;
    end
    if (avs_write && !st_ff.waitreq) begin
      unique case (avs_address)
        `REG_MASK: begin
          nxt_st.mask_wr = 1'b1;
          nxt_st.mask_wdata = avs_writedata[`MASK_W-1:0] & `MASK_IMPL;
        end
        `REG_CTRL: begin
          nxt_st.idle_req = avs_writedata[`CTRL_IDLE_BIT];
          nxt_st.pd_req = avs_writedata[`CTRL_PD_BIT];
          nxt_st.lvl = avs_writedata[`CTRL_LVL_LSB +: 2];
        end
        `REG_FLAGCLR: nxt_st.clr = avs_writedata[`CLR_N-1:0];
        default: nxt_st.clr = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= HOST_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.readdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign link.mask_wr = st_ff.mask_wr;
  assign link.mask_wdata = st_ff.mask_wdata;
  assign link.idle_req = st_ff.idle_req;
  assign link.pd_req = st_ff.pd_req;
  assign link.clr = st_ff.clr;
  assign link.lvl = st_ff.lvl;
endmodule
`default_nettype wire

/* hdl/irq_wake_dev.sv */
// Interrupt enable, flag timing and low-power control end
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"
module irq_wake_dev #(
  parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  irq_link_if.dev link, // Core side
  input wire logic ext_request_pin_a_n, // External request pin 0, async
  input wire logic ext_request_pin_b_n, // External request pin 1, async
  input wire logic reset_pin, // Hardware reset pin, async
  input wire logic timer0_ovf, // Timer 0 overflow pulse
  input wire logic timer1_ovf, // Timer 1 overflow pulse
  input wire logic timer2_ovf, // Timer 2 overflow pulse
  input wire logic timer2_ext_evt, // Timer 2 external event pulse
  input wire logic spi_req, // SPI request level
  input wire logic uart_req, // UART request level
  input wire logic ext_prog_mem, // External program memory in use
  output logic osc_run, // Oscillator running
  output logic periph_run, // Peripherals clocked
  output logic ram_wr_block, // Internal RAM writes inhibited
  output logic sfr_reinit, // Register reinitialise pulse
  output logic ale_out, // Address latch strobe
  output logic program_store_strobe, // Program store strobe
  output logic port0_float, // Port 0 released
  output logic port2_addr, // Port 2 shows address
  output logic ports_hold, // Ports hold latched data
  output var irq_pkg::lp_mode_t lp_mode // Low-power mode
);
  import irq_pkg::*;

  // Synchroniser reset: request pins idle high, reset and memory pins low
  localparam logic [3:0] SYNC_RST = 4'b0011;
  localparam logic [`WAKE_CNT_W-1:0] WAKE_END = `WAKE_CNT_W'(WAKE_CYCLES - 1);
  localparam logic [`WAKE_CNT_W-1:0] GRACE_END = `WAKE_CNT_W'(`GRACE_MCYC * `MCYC_LEN - 1);

  dev_state_t st_ff;
  dev_state_t nxt_st;
  logic [3:0] pins_s;
  logic pa;
  logic pb;
  logic rp;
  logic [`SRC_N-1:0] req;
  logic [`SRC_N-1:0] lvl_req;
  logic [`SRC_N-1:0] en;
  logic pd_wake;
  logic set0;
  logic set1;
  logic set2;
  logic low_pw;
  logic xpm;
  logic grace_done;

  // Requests gated by own enable and by the global enable
  function automatic logic [`SRC_N-1:0] enabled_req(input logic [`SRC_N-1:0] r,
                                                     input logic [`MASK_W-1:0] m);
    enabled_req = r & m[`SRC_N-1:0] & {`SRC_N{m[`MASK_GLOBAL_BIT]}};
  endfunction

  // Pins cross into the core clock
  pin_sync2 #(.W(4), .RST_VAL(SYNC_RST)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .d({ext_prog_mem, reset_pin, ext_request_pin_b_n, ext_request_pin_a_n}),
    .q(pins_s)
  );

  assign pa = pins_s[0];
  assign pb = pins_s[1];
  assign rp = pins_s[2];
  assign xpm = pins_s[3];

  // Six sources at their enable bit positions
  always_comb begin
    req = '0;
    req[`MASK_X0_BIT] = link.lvl[0] ? ~pa : st_ff.x0f;
    req[`MASK_T0_BIT] = st_ff.timer0_overflow_flag;
    req[`MASK_X1_BIT] = link.lvl[1] ? ~pb : st_ff.x1f;
    req[`MASK_T1_BIT] = st_ff.timer1_overflow_flag;
    req[`MASK_SER_BIT] = spi_req | uart_req;
    req[`MASK_T2_BIT] = st_ff.timer2_overflow_flag | st_ff.timer2_external_flag;
    lvl_req = '0;
    lvl_req[`MASK_X0_BIT] = link.lvl[0] & ~pa;
    lvl_req[`MASK_X1_BIT] = link.lvl[1] & ~pb;
  end

  assign en = enabled_req(req, st_ff.mask);
  assign pd_wake = |enabled_req(lvl_req, st_ff.mask);
  assign set0 = (st_ff.phase == `STATE5_PHASE2) & (st_ff.t0p | timer0_ovf);
  assign set1 = (st_ff.phase == `STATE5_PHASE2) & (st_ff.t1p | timer1_ovf);
  assign set2 = (st_ff.phase == `STATE2_PHASE2) & (st_ff.t2p | timer2_ovf);

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sfr_reinit = 1'b0;
    // Machine cycle phases stop with the peripheral clocks
    if (st_ff.mode != LP_PDOWN && st_ff.mode != LP_PD_WAKE) begin
      nxt_st.phase = (st_ff.phase == `PHASE_LAST) ? 4'h0 : 4'(st_ff.phase + 4'h1);
    end
    // Overflows wait for their set point; a set beats a clear
    nxt_st.t0p = (st_ff.t0p | timer0_ovf) & ~set0;
    nxt_st.t1p = (st_ff.t1p | timer1_ovf) & ~set1;
    nxt_st.t2p = (st_ff.t2p | timer2_ovf) & ~set2;
    nxt_st.timer0_overflow_flag = (st_ff.timer0_overflow_flag & ~link.clr[0]) | set0;
    nxt_st.timer1_overflow_flag = (st_ff.timer1_overflow_flag & ~link.clr[1]) | set1;
    nxt_st.timer2_overflow_flag = (st_ff.timer2_overflow_flag & ~link.clr[2]) | set2;
    nxt_st.timer2_external_flag = (st_ff.timer2_external_flag & ~link.clr[3]) | timer2_ext_evt;
    // Falling pin edges latch in edge mode
    nxt_st.pa_d = pa;
    nxt_st.pb_d = pb;
    nxt_st.x0f = (st_ff.x0f & ~link.clr[4]) | (~link.lvl[0] & st_ff.pa_d & ~pa);
    nxt_st.x1f = (st_ff.x1f & ~link.clr[5]) | (~link.lvl[1] & st_ff.pb_d & ~pb);
    // Poll point: timer 0/1 set here is seen one machine cycle later
    if (st_ff.phase == `STATE5_PHASE2) begin
      nxt_st.pending = en;
      nxt_st.irq_req = |en;
    end
    // Mask writes; the reserved bit is never stored
    if (link.mask_wr) begin
      nxt_st.mask = link.mask_wdata & `MASK_IMPL;
    end
    // Low-power mode transitions
    unique case (st_ff.mode)
      LP_RUN: begin
        if (link.pd_req) begin
          nxt_st.mode = LP_PDOWN;
        end else if (link.idle_req) begin
          nxt_st.mode = LP_IDLE;
        end
      end
      LP_IDLE: begin
        if (rp) begin
          nxt_st.mode = LP_GRACE;
          nxt_st.cnt = '0;
        end else if (|en) begin
          nxt_st.mode = LP_RUN;
        end
      end
      LP_PDOWN: begin
        if (!rp && pd_wake) begin
          nxt_st.mode = LP_PD_WAKE;
          nxt_st.cnt = '0;
        end
      end
      LP_PD_WAKE: begin
        nxt_st.cnt = `WAKE_CNT_W'(st_ff.cnt + 1'b1);
        if (st_ff.cnt == WAKE_END) begin
          nxt_st.mode = LP_RUN;
        end
      end
      LP_GRACE: begin
        nxt_st.cnt = `WAKE_CNT_W'(st_ff.cnt + 1'b1);
      end
      default: begin
        nxt_st.mode = LP_RUN;
      end
    endcase
    // Grace ends in the internal reset even if the pin has gone low
    grace_done = (st_ff.mode == LP_GRACE) && (st_ff.cnt == GRACE_END);
    // Reset pin reinitialises registers; RAM is outside and untouched
    if ((rp && (st_ff.mode != LP_IDLE) && (st_ff.mode != LP_GRACE)) || grace_done) begin
      nxt_st = DEV_RESET;
      nxt_st.sfr_reinit = 1'b1;
    end
    // Pin and clock states follow the next mode
    low_pw = (nxt_st.mode == LP_IDLE) | (nxt_st.mode == LP_PDOWN) | (nxt_st.mode == LP_PD_WAKE);
    nxt_st.cpu_run = (nxt_st.mode == LP_RUN) | (nxt_st.mode == LP_GRACE);
    nxt_st.periph_run = (nxt_st.mode != LP_PDOWN) & (nxt_st.mode != LP_PD_WAKE);
    nxt_st.osc_run = nxt_st.mode != LP_PDOWN;
    nxt_st.ram_wr_block = nxt_st.mode == LP_GRACE;
    nxt_st.ports_hold = low_pw;
    nxt_st.ale = (nxt_st.mode == LP_IDLE) | (!low_pw && (nxt_st.phase[2:1] == 2'b00));
    nxt_st.prog_strobe = (nxt_st.mode == LP_IDLE) | (!low_pw && !(xpm && nxt_st.phase[0]));
    nxt_st.port0_float = low_pw & xpm;
    nxt_st.port2_addr = (nxt_st.mode == LP_IDLE) & xpm;
  end

  // State register; Idle only freezes the core, not this block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= DEV_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state
  assign link.mask_rdata = st_ff.mask;
  assign link.pending = st_ff.pending;
  assign link.irq_req = st_ff.irq_req;
  assign link.cpu_run = st_ff.cpu_run;
  assign link.lp_mode = st_ff.mode;
  assign lp_mode = st_ff.mode;
  assign osc_run = st_ff.osc_run;
  assign periph_run = st_ff.periph_run;
  assign ram_wr_block = st_ff.ram_wr_block;
  assign sfr_reinit = st_ff.sfr_reinit;
  assign ale_out = st_ff.ale;
  assign program_store_strobe = st_ff.prog_strobe;
  assign port0_float = st_ff.port0_float;
  assign port2_addr = st_ff.port2_addr;
  assign ports_hold = st_ff.ports_hold;
endmodule
`default_nettype wire

/* hdl/pin_sync2.sv */
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] d, // Raw pins
  output logic [W-1:0] q // Synchronised pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  // Shift stages
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  // Stage registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule
`default_nettype wire

/* inc/irq_link_if.sv */
// Link between the interrupt/wake device and its controlling core
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"
interface irq_link_if;
  logic mask_wr;
  logic [`MASK_W-1:0] mask_wdata;
  logic idle_req;
  logic pd_req;
  logic [`CLR_N-1:0] clr;
  logic [1:0] lvl;
  logic [`MASK_W-1:0] mask_rdata;
  logic [`SRC_N-1:0] pending;
  logic irq_req;
  logic cpu_run;
  irq_pkg::lp_mode_t lp_mode;

  modport dev (input mask_wr, mask_wdata, idle_req, pd_req, clr, lvl,
    output mask_rdata, pending, irq_req, cpu_run, lp_mode);
  modport core (output mask_wr, mask_wdata, idle_req, pd_req, clr, lvl,
    input mask_rdata, pending, irq_req, cpu_run, lp_mode);
endinterface
`default_nettype wire

/* inc/irq_pkg.sv */
// Types for the interrupt enable and low-power wake block
`include "irq_wake_cfg.svh"
package irq_pkg;
  typedef enum logic [2:0] {
    LP_RUN = 3'b000,
    LP_IDLE = 3'b001,
    LP_PDOWN = 3'b010,
    LP_PD_WAKE = 3'b011,
    LP_GRACE = 3'b100
  } lp_mode_t;

  typedef struct packed {
    lp_mode_t mode;
    logic [3:0] phase;
    logic [`WAKE_CNT_W-1:0] cnt;
    logic [`MASK_W-1:0] mask;
    logic t0p;
    logic t1p;
    logic t2p;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic x0f;
    logic x1f;
    logic pa_d;
    logic pb_d;
    logic [`SRC_N-1:0] pending;
    logic irq_req;
    logic cpu_run;
    logic osc_run;
    logic periph_run;
    logic ram_wr_block;
    logic sfr_reinit;
    logic ale;
    logic prog_strobe;
    logic port0_float;
    logic port2_addr;
    logic ports_hold;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{mode: LP_RUN, mask: `MASK_RESET, pa_d: 1'b1, pb_d: 1'b1,
    cpu_run: 1'b1, osc_run: 1'b1, periph_run: 1'b1, ale: 1'b1, prog_strobe: 1'b1, default: '0};

  typedef struct packed {
    logic waitreq;
    logic [31:0] readdata;
    logic mask_wr;
    logic [`MASK_W-1:0] mask_wdata;
    logic idle_req;
    logic pd_req;
    logic [`CLR_N-1:0] clr;
    logic [1:0] lvl;
  } host_state_t;

  localparam host_state_t HOST_RESET = '{waitreq: 1'b1, default: '0};
endpackage

/* inc/irq_wake_cfg.svh */
// Constants for the interrupt enable and low-power wake block
`ifndef IRQ_WAKE_CFG_SVH
`define IRQ_WAKE_CFG_SVH
// Enable mask layout
`define MASK_W 8
`define SRC_N 6
`define MASK_GLOBAL_BIT 7
`define MASK_RSVD_BIT 6
`define MASK_T2_BIT 5
`define MASK_SER_BIT 4
`define MASK_T1_BIT 3
`define MASK_X1_BIT 2
`define MASK_T0_BIT 1
`define MASK_X0_BIT 0
`define MASK_RESET 8'h00
`define MASK_IMPL 8'hbf
// Machine cycle: six states of two phases, index (state-1)*2+(phase-1)
`define PHASE_LAST 4'hb
`define STATE5_PHASE2 4'h9
`define STATE2_PHASE2 4'h3
`define MCYC_LEN 12
`define GRACE_MCYC 2
// Wake delay from power down
`define WAKE_TIME_MS 16
`define CLK_KHZ 125000
`define WAKE_CYCLES (`WAKE_TIME_MS * `CLK_KHZ)
`define WAKE_CNT_W 22
// Host register map, byte addresses
`define AVS_ADDR_W 4
`define REG_MASK 4'h0
`define REG_CTRL 4'h4
`define REG_FLAGCLR 4'h8
`define REG_STATUS 4'hc
`define CTRL_IDLE_BIT 0
`define CTRL_PD_BIT 1
`define CTRL_LVL_LSB 2
`define STAT_IRQ_BIT 8
`define STAT_MODE_LSB 9
`define STAT_RUN_BIT 12
`define CLR_N 6
`endif

/* verif/irq_link_checker.sv */
// Concurrent checks on the link joining the core and device ends
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"
module irq_link_checker #(
  parameter int WAKE_CYCLES = 20
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Async reset
  input wire logic mask_wr, // Mask write pulse
  input wire logic [`MASK_W-1:0] mask_wdata, // Value written
  input wire logic idle_req, // Idle request
  input wire logic pd_req, // Power down request
  input wire logic [`MASK_W-1:0] mask_rdata, // Stored mask
  input wire logic [`SRC_N-1:0] pending, // Polled requests
  input wire logic irq_req, // Any request
  input wire logic cpu_run, // Core running
  input wire irq_pkg::lp_mode_t lp_mode // Low-power mode
);
  import irq_pkg::*;
  int unsigned wk_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Cycles spent in the wake delay
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) wk_ff <= 0;
    else wk_ff <= (lp_mode == LP_PD_WAKE) ? wk_ff + 1 : 0;
  end
  a_mask_store: assert property (
    mask_wr |=> mask_rdata == (mask_wdata & 8'hbf)) else $error("mask readback wrong");
  a_rsvd_zero: assert property (mask_rdata[6] == 1'b0) else $error("reserved bit set");
  a_irq_any: assert property (irq_req == (|pending)) else $error("irq_req not OR of pending");
  a_gate_rise: assert property (
    ((pending & ~$past(pending)) & ~($past(mask_rdata[5:0]) & {6{$past(mask_rdata[7])}})) == 6'h00)
    else $error("disabled source became pending");
  a_idle_entry: assert property (
    idle_req && !pd_req && lp_mode == LP_RUN |=> lp_mode == LP_IDLE) else $error("idle not entered");
  a_pd_entry: assert property (
    pd_req && lp_mode == LP_RUN |=> lp_mode == LP_PDOWN) else $error("power down not entered");
  a_idle_halt: assert property (lp_mode == LP_IDLE |-> !cpu_run) else $error("core runs in idle");
  a_grace_run: assert property (
    lp_mode inside {LP_RUN, LP_GRACE} |-> cpu_run) else $error("core stopped while running");
  a_idle_wake: assert property (
    $rose(irq_req) |-> ##[0:1] lp_mode != LP_IDLE) else $error("idle kept with request");
  a_wake_bound: assert property (
    lp_mode == LP_PD_WAKE |-> wk_ff < WAKE_CYCLES) else $error("wake delay too long");
  a_wake_len: assert property (
    $past(lp_mode) == LP_PD_WAKE && lp_mode == LP_RUN |-> wk_ff == WAKE_CYCLES)
    else $error("wake delay length wrong");
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench joining the core and device ends
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_cfg.svh"
`define check_eq(nm, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module testbench;
  import irq_pkg::*;
  localparam int WK = 20;
  logic sys_clk = 0, rst = 1, rd = 0, wr = 0, pa_n = 1, pb_n = 1, rpin = 0, wreq;
  logic t0 = 0, t1 = 0, t2 = 0, t2e = 0, spi = 0, uart = 0, epm = 0, ce = 1;
  logic osc, per, rwb, sfr, ale, pss, p0f, p2a, phold;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata, lfsr = 32'h38249f74;
  logic [31:0] expq[$];
  lp_mode_t mode;
  int errors = 0, num_checks = 0, n, cyc = 0, tp, k0, k2;
  irq_link_if link();
  irq_wake_core u_irq_wake_core (.sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq), .link(link.core));
  irq_wake_dev #(.WAKE_CYCLES(WK)) u_irq_wake_dev (.sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link.dev),
    .ext_request_pin_a_n(pa_n), .ext_request_pin_b_n(pb_n), .reset_pin(rpin), .timer0_ovf(t0),
    .timer1_ovf(t1), .timer2_ovf(t2), .timer2_ext_evt(t2e), .spi_req(spi), .uart_req(uart),
    .ext_prog_mem(epm), .osc_run(osc), .periph_run(per), .ram_wr_block(rwb), .sfr_reinit(sfr),
    .ale_out(ale), .program_store_strobe(pss), .port0_float(p0f), .port2_addr(p2a),
    .ports_hold(phold), .lp_mode(mode));
  irq_link_checker #(.WAKE_CYCLES(WK)) u_irq_link_checker (.sys_clk(sys_clk), .rst(rst),
    .mask_wr(link.mask_wr), .mask_wdata(link.mask_wdata), .idle_req(link.idle_req), .pd_req(link.pd_req),
    .mask_rdata(link.mask_rdata), .pending(link.pending), .irq_req(link.irq_req),
    .cpu_run(link.cpu_run), .lp_mode(link.lp_mode));
  // Clock and free cycle count
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected status word
  function automatic logic [31:0] st(input logic [5:0] p, input lp_mode_t m, input logic r);
    return {19'h0, r, m, |p, 2'b00, p};
  endfunction
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    {addr, wr, rd, wdata} <= {a, w, !w, d};
    do begin
      @(posedge sys_clk);
    end while (wreq !== 1'b0);
    {wr, rd} <= 2'b00;
  endtask
  task automatic wrx(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wait_mode(input lp_mode_t m);
    int t;
    t = 0;
    while (mode !== m && t < 200) begin
      @(posedge sys_clk);
      t++;
    end
    `check_eq("lp_mode", m, mode)
  endtask
  task automatic count_in(input lp_mode_t m, output int c);
    c = 0;
    while (mode === m && c < 60) begin
      @(posedge sys_clk);
      c++;
    end
  endtask
  // Timer pulses for one cycle, pin falls held four cycles
  task automatic fire(input logic [5:0] s);
    @(posedge sys_clk);
    {t2e, t2, t1, t0, pb_n, pa_n} <= {s[3:0], ~s[5:4]};
    @(posedge sys_clk);
    {t2e, t2, t1, t0} <= 4'h0;
    repeat (3) @(posedge sys_clk);
    {pb_n, pa_n} <= 2'b11;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read data against the oldest note
  always @(posedge sys_clk) begin
    if (rd && wreq === 1'b0 && expq.size() > 0) begin
      `check_eq("readdata", expq[0], rdata)
      expq.delete(0);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdx(`REG_MASK, 32'h0);
    rdx(`REG_STATUS, st(6'h00, LP_RUN, 1'b1));
    wrx(4'h2, 32'hff);
    rdx(4'h2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_step(lfsr);
      wrx(`REG_MASK, lfsr);
      rdx(`REG_MASK, lfsr & 32'hbf);
    end
    // Poll delay of timer 0 against timer 2, aligned on the strobe
    wrx(`REG_MASK, 32'ha2);
    n = 0;
    while (n < 7) begin
      @(posedge sys_clk);
      n = (ale === 1'b0) ? n + 1 : ((n >= 6) ? 7 : 0);
    end
    repeat (2) @(posedge sys_clk);
    tp = cyc;
    fire(6'h05);
    {k0, k2} = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (link.pending[5] === 1'b1 && k2 == 0) k2 = cyc;
      if (link.pending[1] === 1'b1 && k0 == 0) k0 = cyc;
    end
    `check_eq("timer0 lag", k2 + 12, k0)
    `check_eq("timer2 lag", 1'b1, k2 > 0 && k2 - tp < 16)
    // Each source alone, then all with the global bit off
    for (int k = 0; k < 7; k++) begin
      wrx(`REG_FLAGCLR, 32'h3f);
      wrx(`REG_MASK, (k == 6) ? 32'h3f : 32'h80 | (32'h1 << k));
      lfsr = lfsr_step(lfsr);
      {spi, uart} <= {lfsr[0], !lfsr[0]};
      fire(6'h3f);
      repeat (30) @(posedge sys_clk);
      rdx(`REG_STATUS, st((k == 6) ? 6'h00 : 6'h01 << k, LP_RUN, 1'b1));
    end
    {spi, uart} <= 2'b00;
    // Timer 2 event flag alone, cleared only by its own clear
    wrx(`REG_FLAGCLR, 32'h3f);
    wrx(`REG_MASK, 32'ha0);
    fire(6'h08);
    repeat (30) @(posedge sys_clk);
    rdx(`REG_STATUS, st(6'h20, LP_RUN, 1'b1));
    wrx(`REG_FLAGCLR, 32'h04);
    repeat (30) @(posedge sys_clk);
    rdx(`REG_STATUS, st(6'h20, LP_RUN, 1'b1));
    wrx(`REG_FLAGCLR, 32'h08);
    repeat (30) @(posedge sys_clk);
    rdx(`REG_STATUS, st(6'h00, LP_RUN, 1'b1));
    // Idle, pin states, wake by pin edge
    epm <= lfsr[1];
    wrx(`REG_MASK, 32'h81);
    wrx(`REG_CTRL, 32'h1);
    rdx(`REG_STATUS, st(6'h00, LP_IDLE, 1'b0));
    `check_eq("idle strobes", 2'b11, {ale, pss})
    `check_eq("idle ports", {1'b1, epm, 2'b11}, {p0f === epm, p2a, phold, per})
    fire(6'h10);
    wait_mode(LP_RUN);
    rdx(`REG_MASK, 32'h81);
    // Hardware reset out of idle
    wrx(`REG_FLAGCLR, 32'h3f);
    wrx(`REG_CTRL, 32'h1);
    wait_mode(LP_IDLE);
    rpin <= 1'b1;
    wait_mode(LP_GRACE);
    `check_eq("grace", 2'b11, {rwb, link.cpu_run})
    count_in(LP_GRACE, n);
    `check_eq("grace length", 24, n)
    @(posedge sys_clk);
    `check_eq("sfr reinit", 1'b1, sfr)
    rpin <= 1'b0;
    rdx(`REG_MASK, 32'h0);
    // Power down, timers ignored, level pin wake
    wrx(`REG_MASK, 32'hab);
    wrx(`REG_CTRL, 32'h6);
    wait_mode(LP_PDOWN);
    `check_eq("pd pins", 6'h05, {osc, ale, pss, p0f === epm, p2a, phold})
    fire(6'h0f);
    repeat (30) @(posedge sys_clk);
    `check_eq("pd kept", LP_PDOWN, mode)
    pa_n <= 1'b0;
    wait_mode(LP_PD_WAKE);
    count_in(LP_PD_WAKE, n);
    `check_eq("wake length", WK, n)
    wait_mode(LP_RUN);
    pa_n <= 1'b1;
    rdx(`REG_MASK, 32'hab);
    // Power down left by hardware reset
    wrx(`REG_CTRL, 32'h6);
    wait_mode(LP_PDOWN);
    rpin <= 1'b1;
    wait_mode(LP_RUN);
    rpin <= 1'b0;
    rdx(`REG_MASK, 32'h0);
    // Clock enable low freezes the strobe waveform
    ce <= 1'b0;
    @(posedge sys_clk);
    k0 = ale;
    repeat (6) begin
      @(posedge sys_clk);
      `check_eq("ce freeze", k0[0], ale)
    end
    ce <= 1'b1;
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
